/* hdl/bert_core.sv */
// Function
// - transmit load copies pattern set, restarts generator
// - loaded MSB leaves on third tx edge
// - load trigger is pin OR control bit
// - pseudorandom sync after 34 plus n clean bits
// - while synced, each mismatch bumps error count
// - receiver checks transmit feedback polynomial
// - all ones or zeros also pass check while hunting
// - repetitive sync on matching repetition length
// - sync enable and resync bits govern receiver
// - load count sets integration period
// - first tap fixed at length minus one
// - second tap programmable to any position
// - lengths 1 to 32 supported
// - single error or decade rate insertion
// - error insert register steers injection
// - test input floats link outputs
// - transmit and receive run independently
// - receiver searches incoming data for pattern
// - load count latches counts, clears counters
// - load count trigger is pin OR bit
`timescale 1ns/10ps

module bert_core #(
    parameter int PAT_W = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // register bus write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // control pins
    input wire logic transmit_load,
    input wire logic load_count,
    input wire logic test_mode,
    // transmit link
    input wire logic tx_bit_clock,
    output logic tx_data_out,
    output logic tx_data_oe,
    // receive link
    input wire logic rx_bit_clock,
    input wire logic rx_data_in,
    output logic rx_sync_loss_out,
    output logic rx_sync_loss_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] tx_bit_clock_s;
        logic [1:0] rclk_s;
        logic [1:0] rdat_s;
        logic [1:0] tl_s;
        logic [1:0] lc_s;
        logic [1:0] test_s;
        logic tx_bit_clock_d;
        logic rclk_d;
        logic tl_d;
        logic lc_d;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [bert_pkg::PCR_W-1:0] pattern_control_reg;
        logic [PAT_W-1:0] pattern_set_regs;
        logic [4:0] pattern_length_reg;
        logic [4:0] feedback_tap_reg;
        logic [bert_pkg::EIR_W-1:0] error_insert_reg;
        logic [PAT_W-1:0] gen;
        logic [1:0] hold;
        logic tx_data;
        logic [23:0] rate_cnt;
        logic [PAT_W-1:0] rxs;
        logic [PAT_W-1:0] ref_pat;
        logic locked;
        logic [6:0] match_cnt;
        logic [5:0] win_cnt;
        logic [3:0] win_err;
        logic [31:0] bit_cnt;
        logic [31:0] err_cnt;
        logic [31:0] bit_count_reg;
        logic [31:0] bit_error_count_reg;
        logic [PAT_W-1:0] received_pattern_regs;
    } bert_state_s;

    bert_state_s r;
    bert_state_s next_r;

    logic tx_edge;
    logic rx_edge;
    logic tl_edge;
    logic lc_edge;
    logic mode_rpt;
    logic gen_msb;
    logic inject;
    logic exp_bit;
    logic rx_match;
    logic all_ones;
    logic all_zeros;
    logic [5:0] pat_len;
    logic [6:0] sync_thresh;
    logic [PAT_W-1:0] len_mask;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // window mask over the programmed length
    // ------------------------------------------------------------
    for (genvar i = 0; i < PAT_W; i++) begin : g_mask
        assign len_mask[i] = (i <= int'(r.pattern_length_reg));
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wr_merged;
        logic [31:0] rd_val;
        logic [1:0] rd_resp;
        logic fb;
        logic rate_hit;
        logic inc_bit;
        logic inc_err;
        logic [31:0] bit_base;
        logic [31:0] err_base;
        wr_merged = merge(32'h0000_0000, r.wdata, r.wstrb);
        rd_val = 32'h0000_0000;
        rd_resp = bert_pkg::RESP_OKAY;
        fb = 1'b0;
        rate_hit = 1'b0;
        inc_bit = 1'b0;
        inc_err = 1'b0;
        next_r = r;

        // every control pin, link data pin and foreign clock passes two flops first
        next_r.tx_bit_clock_s = {r.tx_bit_clock_s[0], tx_bit_clock};
        next_r.rclk_s = {r.rclk_s[0], rx_bit_clock};
        next_r.rdat_s = {r.rdat_s[0], rx_data_in};
        next_r.tl_s = {r.tl_s[0], transmit_load};
        next_r.lc_s = {r.lc_s[0], load_count};
        next_r.test_s = {r.test_s[0], test_mode};

        // edge detection; tx and rx edges are independent
        next_r.tx_bit_clock_d = r.tx_bit_clock_s[1];
        next_r.rclk_d = r.rclk_s[1];
        tx_edge = r.tx_bit_clock_s[1] & ~r.tx_bit_clock_d;
        rx_edge = r.rclk_s[1] & ~r.rclk_d;
        next_r.tl_d = r.tl_s[1] | r.pattern_control_reg[bert_pkg::PCR_TX_LOAD_BIT];
        tl_edge = next_r.tl_d & ~r.tl_d;
        next_r.lc_d = r.lc_s[1] | r.pattern_control_reg[bert_pkg::PCR_LOAD_COUNT_BIT];
        lc_edge = next_r.lc_d & ~r.lc_d;

        mode_rpt = r.pattern_control_reg[bert_pkg::PCR_MODE_RPT_BIT];
        pat_len = 6'({1'b0, r.pattern_length_reg} + 6'h01);
        sync_thresh = 7'(bert_pkg::SYNC_BASE_BITS + {1'b0, pat_len});

        // transmit generator: tap A at length-1, tap B programmable
        gen_msb = r.gen[r.pattern_length_reg];
        fb = mode_rpt ? gen_msb : (gen_msb ^ r.gen[r.feedback_tap_reg]);
        inject = 1'b0;
        if (tl_edge) begin
            next_r.gen = r.pattern_set_regs;
            next_r.hold = bert_pkg::TX_HOLD_INIT;
            next_r.rate_cnt = 24'h000000;
        end else if (tx_edge) begin
            if (r.hold != 2'h0) begin
                next_r.hold = 2'(r.hold - 2'h1);
            end else begin
                // decade rate counter runs on transmitted bits
                if (r.error_insert_reg[bert_pkg::EIR_RATE_LSB +: bert_pkg::EIR_RATE_W] != 3'h0) begin
                    if (r.rate_cnt >= 24'(bert_pkg::err_period(r.error_insert_reg[2:0]) - 24'h000001)) begin
                        next_r.rate_cnt = 24'h000000;
                        rate_hit = 1'b1;
                    end else begin
                        next_r.rate_cnt = 24'(r.rate_cnt + 24'h000001);
                    end
                end
                inject = rate_hit | r.error_insert_reg[bert_pkg::EIR_SINGLE_BIT];
                next_r.error_insert_reg[bert_pkg::EIR_SINGLE_BIT] = 1'b0;
                next_r.tx_data = gen_msb ^ inject;
                next_r.gen = {r.gen[PAT_W-2:0], fb};
            end
        end

        // receive: predict from history (hunting) or local reference (locked)
        all_ones = &(r.rxs | ~len_mask);
        all_zeros = ~|(r.rxs & len_mask);
        if (r.locked) begin
            exp_bit = mode_rpt ? r.ref_pat[r.pattern_length_reg]
                : (r.ref_pat[r.pattern_length_reg] ^ r.ref_pat[r.feedback_tap_reg]);
        end else begin
            exp_bit = mode_rpt ? r.rxs[r.pattern_length_reg]
                : (r.rxs[r.pattern_length_reg] ^ r.rxs[r.feedback_tap_reg]);
        end
        // an all-ones stream breaks the xor recurrence, so it is let through
        rx_match = (r.rdat_s[1] == exp_bit) | (~mode_rpt & ~r.locked & all_ones & r.rdat_s[1]);

        if (rx_edge) begin
            next_r.rxs = {r.rxs[PAT_W-2:0], r.rdat_s[1]};
            if (r.locked) begin
                next_r.ref_pat = {r.ref_pat[PAT_W-2:0], exp_bit};
                inc_bit = 1'b1;
                inc_err = ~rx_match;
                next_r.win_cnt = 6'(r.win_cnt + 6'h01);
                next_r.win_err = r.win_err + {3'h0, ~rx_match};
                if (next_r.win_err >= bert_pkg::LOS_ERR_LIMIT) begin
                    next_r.locked = 1'b0;
                    next_r.match_cnt = 7'h00;
                end else if (r.win_cnt == bert_pkg::LOS_WINDOW_LAST) begin
                    next_r.win_err = 4'h0;
                end
            end else if (rx_match) begin
                next_r.match_cnt = 7'(r.match_cnt + 7'h01);
                if (7'(r.match_cnt + 7'h01) >= sync_thresh) begin
                    next_r.locked = 1'b1;
                    next_r.match_cnt = 7'h00;
                    next_r.win_cnt = 6'h00;
                    next_r.win_err = 4'h0;
                    next_r.ref_pat = {r.rxs[PAT_W-2:0], r.rdat_s[1]};
                    next_r.received_pattern_regs = {r.rxs[PAT_W-2:0], r.rdat_s[1]};
                end
            end else begin
                next_r.match_cnt = 7'h00;
            end
        end
        // disabled or resync held: drop lock and restart hunting
        if (!r.pattern_control_reg[bert_pkg::PCR_SYNC_EN_BIT] || r.pattern_control_reg[bert_pkg::PCR_RESYNC_BIT]) begin
            next_r.locked = 1'b0;
            next_r.match_cnt = 7'h00;
        end

        // load count latches then clears; this cycle's bit lands in the new period
        bit_base = lc_edge ? 32'h0000_0000 : r.bit_cnt;
        err_base = lc_edge ? 32'h0000_0000 : r.err_cnt;
        if (lc_edge) begin
            next_r.bit_count_reg = r.bit_cnt;
            next_r.bit_error_count_reg = r.err_cnt;
        end
        // counters saturate instead of wrapping to keep the ratio meaningful
        next_r.bit_cnt = (inc_bit && bit_base != 32'hFFFF_FFFF) ? 32'(bit_base + 32'h1) : bit_base;
        next_r.err_cnt = (inc_err && err_base != 32'hFFFF_FFFF) ? 32'(err_base + 32'h1) : err_base;

        // bus write: both halves may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_have = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_have = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (r.aw_have && r.w_have && !r.bvalid) begin
            next_r.aw_have = 1'b0;
            next_r.w_have = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = bert_pkg::RESP_OKAY;
            unique case (r.awaddr)
                bert_pkg::OFF_PATTERN_CONTROL: if (r.wstrb[0]) next_r.pattern_control_reg = wr_merged[7:0];
                bert_pkg::OFF_PATTERN_SET: next_r.pattern_set_regs = merge(r.pattern_set_regs, r.wdata, r.wstrb);
                bert_pkg::OFF_PATTERN_LENGTH: if (r.wstrb[0]) next_r.pattern_length_reg = wr_merged[4:0];
                bert_pkg::OFF_FEEDBACK_TAP: if (r.wstrb[0]) next_r.feedback_tap_reg = wr_merged[4:0];
                // written after the hardware clear, so a new single request wins
                bert_pkg::OFF_ERROR_INSERT: if (r.wstrb[0]) next_r.error_insert_reg = wr_merged[3:0];
                // read-only registers ignore the write and still answer okay
                bert_pkg::OFF_STATUS, bert_pkg::OFF_BIT_COUNT, bert_pkg::OFF_BIT_ERROR_COUNT,
                bert_pkg::OFF_RECEIVED_PATTERN: next_r.bresp = bert_pkg::RESP_OKAY;
                default: next_r.bresp = bert_pkg::RESP_SLVERR;
            endcase
        end
        if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;

        // bus read: answer one cycle after the address is taken
        unique case (s_axi_araddr)
            bert_pkg::OFF_PATTERN_CONTROL: rd_val = {24'h000000, r.pattern_control_reg};
            bert_pkg::OFF_PATTERN_SET: rd_val = r.pattern_set_regs;
            bert_pkg::OFF_PATTERN_LENGTH: rd_val = {27'h0000000, r.pattern_length_reg};
            bert_pkg::OFF_FEEDBACK_TAP: rd_val = {27'h0000000, r.feedback_tap_reg};
            bert_pkg::OFF_ERROR_INSERT: rd_val = {28'h0000000, r.error_insert_reg};
            bert_pkg::OFF_STATUS: begin
                rd_val[bert_pkg::SR_SYNC_BIT] = r.locked;
                rd_val[bert_pkg::SR_ALL_ONES_BIT] = all_ones;
                rd_val[bert_pkg::SR_ALL_ZEROS_BIT] = all_zeros;
            end
            bert_pkg::OFF_BIT_COUNT: rd_val = r.bit_count_reg;
            bert_pkg::OFF_BIT_ERROR_COUNT: rd_val = r.bit_error_count_reg;
            bert_pkg::OFF_RECEIVED_PATTERN: rd_val = r.received_pattern_regs;
            default: rd_resp = bert_pkg::RESP_SLVERR;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = rd_val;
            next_r.rresp = rd_resp;
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // all registers clear; software is still expected to program everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // test input floats link outputs by dropping their enables
    assign s_axi_awready = ~r.aw_have & ~r.bvalid;
    assign s_axi_wready = ~r.w_have & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign tx_data_out = r.tx_data;
    assign tx_data_oe = ~r.test_s[1];
    assign rx_sync_loss_out = ~r.locked;
    assign rx_sync_loss_oe = ~r.test_s[1];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_load_restart: assert property (tl_edge |=> (r.gen == $past(r.pattern_set_regs))
        && r.hold == bert_pkg::TX_HOLD_INIT)
        else $error("generator not reloaded on transmit load");
    a_load_or_bit: assert property ((r.pattern_control_reg[bert_pkg::PCR_TX_LOAD_BIT] && !r.tl_d) |-> tl_edge)
        else $error("control bit did not trigger transmit load");
    a_hold_edges: assert property ((tx_edge && r.hold != 2'h0 && !tl_edge)
        |=> r.hold == $past(r.hold) - 2'h1 && $stable(r.tx_data))
        else $error("transmit hold not counting edges");
    a_third_edge_msb: assert property ((tx_edge && r.hold == 2'h0 && !tl_edge && !inject)
        |=> r.tx_data == $past(gen_msb))
        else $error("pattern msb not sent");
    a_sync_threshold: assert property ($rose(r.locked) |-> $past(r.match_cnt) == $past(sync_thresh) - 7'h01)
        else $error("sync declared at wrong bit count");
    a_err_count_step: assert property ((rx_edge && r.locked && !rx_match && !lc_edge
        && r.err_cnt != 32'hFFFF_FFFF) |=> r.err_cnt == $past(r.err_cnt) + 32'h1)
        else $error("mismatch while synced not counted");
    a_no_count_unsync: assert property ((!r.locked && !lc_edge) |=> $stable(r.err_cnt) && $stable(r.bit_cnt))
        else $error("counting while not synced");
    a_sync_disable: assert property (!r.pattern_control_reg[bert_pkg::PCR_SYNC_EN_BIT] |=> !r.locked)
        else $error("lock held with sync disabled");
    a_count_latch: assert property (lc_edge |=> r.bit_count_reg == $past(r.bit_cnt)
        && r.bit_error_count_reg == $past(r.err_cnt) && r.bit_cnt <= 32'h1)
        else $error("load count did not latch and clear");
    a_test_float: assert property (r.test_s[1] |-> !tx_data_oe && !rx_sync_loss_oe)
        else $error("outputs driven in test mode");
endmodule // bert_core

/* hdl/bert_pkg.sv */
package bert_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PATTERN_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PATTERN_SET = 8'h04;
    localparam logic [7:0] OFF_PATTERN_LENGTH = 8'h08;
    localparam logic [7:0] OFF_FEEDBACK_TAP = 8'h0C;
    localparam logic [7:0] OFF_ERROR_INSERT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_BIT_COUNT = 8'h18;
    localparam logic [7:0] OFF_BIT_ERROR_COUNT = 8'h1C;
    localparam logic [7:0] OFF_RECEIVED_PATTERN = 8'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int PCR_MODE_RPT_BIT = 0;
    localparam int PCR_SYNC_EN_BIT = 1;
    localparam int PCR_RESYNC_BIT = 2;
    localparam int PCR_LOAD_COUNT_BIT = 4;
    localparam int PCR_TX_LOAD_BIT = 7;
    localparam int PCR_W = 8;
    localparam int EIR_RATE_LSB = 0;
    localparam int EIR_RATE_W = 3;
    localparam int EIR_SINGLE_BIT = 3;
    localparam int EIR_W = 4;
    localparam int SR_SYNC_BIT = 0;
    localparam int SR_ALL_ONES_BIT = 1;
    localparam int SR_ALL_ZEROS_BIT = 2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing, synchroniser and bus response constants
    // ------------------------------------------------------------
    localparam int TX_LOAD_EDGES = 3;
    localparam logic [1:0] TX_HOLD_INIT = 2'(TX_LOAD_EDGES - 1);
    localparam logic [6:0] SYNC_BASE_BITS = 7'h22;
    localparam logic [5:0] LOS_WINDOW_LAST = 6'h3F;
    localparam logic [3:0] LOS_ERR_LIMIT = 4'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bits between forced errors for each decade rate code
    function automatic logic [23:0] err_period(input logic [2:0] rate);
        unique case (rate)
            3'h1: err_period = 24'h00000A;
            3'h2: err_period = 24'h000064;
            3'h3: err_period = 24'h0003E8;
            3'h4: err_period = 24'h002710;
            3'h5: err_period = 24'h0186A0;
            3'h6: err_period = 24'h0F4240;
            3'h7: err_period = 24'h989680;
            default: err_period = 24'h000000;
        endcase
    endfunction

endpackage

/* test/bert_link_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// far-end link: bit clock source with transmit looped to receive
// ------------------------------------------------------------
module bert_link_model (
    // bench control
    input wire logic run,
    // device transmit pins
    input wire logic tx_data_out,
    input wire logic tx_data_oe,
    // device clock and receive pins
    output logic tx_bit_clock,
    output logic rx_bit_clock,
    output logic rx_data_in,
    // observation of the transmit stream
    output int edges,
    output logic [31:0] seen
);
    logic held = 1'b0;

    // 800 ns bit period; clock stands low while run is low
    // short high phase: sampling just before each rise stays clear of the data change
    initial begin
        tx_bit_clock = 1'b0;
        edges = 0;
        seen = 32'h0000_0000;
        forever begin
            #395;
            if (run) begin
                seen = {seen[30:0], tx_data_out};
                #5 tx_bit_clock = 1'b1;
                edges++;
                #200 tx_bit_clock = 1'b0;
                #200;
            end else begin
                #405;
            end
        end
    end

    assign rx_bit_clock = tx_bit_clock;
    // a released line shows the inverse of its last driven level, never a stale copy
    always @(tx_data_out or tx_data_oe) if (tx_data_oe) held = tx_data_out;
    assign rx_data_in = tx_data_oe ? tx_data_out : ~held;
endmodule // bert_link_model

/* test/bert_core_test.sv */
`timescale 1ns/10ps

module bert_core_test;
    logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seen, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic transmit_load = 1'b0, load_count = 1'b0, test_mode = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic tx_bit_clock, rx_bit_clock, rx_data_in, tx_data_out, tx_data_oe, rx_sync_loss_out, rx_sync_loss_oe;
    int edges, e0, miscompares = 0, samples_checked = 0;

    bert_core bert_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .transmit_load,
        .load_count, .test_mode, .tx_bit_clock, .tx_data_out, .tx_data_oe, .rx_bit_clock, .rx_data_in,
        .rx_sync_loss_out, .rx_sync_loss_oe);
    bert_link_model bert_link_model_i (.run, .tx_data_out, .tx_data_oe, .tx_bit_clock, .rx_bit_clock,
        .rx_data_in, .edges, .seen);

    // 10 MHz bus clock
    initial begin
        forever #50 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // compare, bus tasks and verdict
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // each channel drops right after the edge that takes it; the answer is taken at the edge where it stands
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic rb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            rb = s_axi_bvalid;
            r = s_axi_bresp;
        end while (!rb);
        s_axi_bready <= 1'b0;
        chk({30'h0, r}, {30'h0, bert_pkg::RESP_OKAY});
    endtask

    task automatic rd(input logic [7:0] a);
        logic rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end while (!rv);
        s_axi_rready <= 1'b0;
        // an error answer carries no data
        if (r !== bert_pkg::RESP_OKAY) chk(d, 32'h0000_0000);
    endtask

    task automatic bits(input int k);
        repeat (k * 8) @(posedge aclk);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang costs a mismatch; the tests need under 3000 cycles
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        int n;
        n = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(bert_pkg::OFF_STATUS);
        // nothing received yet: history reads as all zeros, not synced
        chk(d, 32'h0000_0001 << bert_pkg::SR_ALL_ZEROS_BIT);
        chk({31'h0, rx_sync_loss_out}, 32'h0000_0001);
        rd(8'h40);
        chk({d[29:0], r}, {30'h0, bert_pkg::RESP_SLVERR});
        $display("test reset and unmapped done");
        // repetitive 8-bit pattern, loaded by the pin while the link clock stands
        wr(bert_pkg::OFF_PATTERN_SET, 32'h0000_00A5);
        wr(bert_pkg::OFF_PATTERN_LENGTH, 32'h0000_0007);
        wr(bert_pkg::OFF_FEEDBACK_TAP, 32'h0000_0000);
        wr(bert_pkg::OFF_ERROR_INSERT, 32'h0000_0000);
        wr(bert_pkg::OFF_PATTERN_CONTROL, 32'h0000_0003);
        transmit_load <= 1'b1;
        repeat (6) @(posedge aclk);
        transmit_load <= 1'b0;
        e0 = edges;
        run <= 1'b1;
        while (edges < e0 + 11 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk({24'h0, seen[7:0]}, 32'h0000_00A5);
        $display("test transmit load done");
        bits(60);
        rd(bert_pkg::OFF_STATUS);
        chk(d, 32'h0000_0001);
        chk({31'h0, rx_sync_loss_out}, 32'h0000_0000);
        // lock came on the 42nd clean bit after the last start-up mismatch: A5 rotated left by two
        rd(bert_pkg::OFF_RECEIVED_PATTERN);
        chk(d, 32'h9696_9696);
        // one forced error in a period of exactly 20 bits; the link clock stands at both load-count edges
        run <= 1'b0;
        load_count <= 1'b1;
        repeat (6) @(posedge aclk);
        load_count <= 1'b0;
        e0 = edges;
        run <= 1'b1;
        wr(bert_pkg::OFF_ERROR_INSERT, 32'h0000_0008);
        while (edges < e0 + 20) @(posedge aclk);
        run <= 1'b0;
        wr(bert_pkg::OFF_PATTERN_CONTROL, 32'h0000_0013);
        wr(bert_pkg::OFF_PATTERN_CONTROL, 32'h0000_0003);
        rd(bert_pkg::OFF_BIT_ERROR_COUNT);
        chk(d, 32'h0000_0001);
        rd(bert_pkg::OFF_BIT_COUNT);
        chk(d, 32'h0000_0014);
        rd(bert_pkg::OFF_ERROR_INSERT);
        chk(d, 32'h0000_0000);
        run <= 1'b1;
        $display("test error insertion done");
        // pseudorandom length 7, second tap 5, loaded by the control bit, hunting held by resync
        wr(bert_pkg::OFF_PATTERN_LENGTH, 32'h0000_0006);
        wr(bert_pkg::OFF_FEEDBACK_TAP, 32'h0000_0005);
        wr(bert_pkg::OFF_PATTERN_SET, 32'h0000_007F);
        wr(bert_pkg::OFF_PATTERN_CONTROL, 32'h0000_0086);
        wr(bert_pkg::OFF_PATTERN_CONTROL, 32'h0000_0002);
        bits(30);
        rd(bert_pkg::OFF_STATUS);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        bits(30);
        rd(bert_pkg::OFF_STATUS);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        $display("test pseudorandom sync done");
        test_mode <= 1'b1;
        repeat (5) @(posedge aclk);
        chk({30'h0, tx_data_oe, rx_sync_loss_oe}, 32'h0000_0000);
        $display("test output float done");
        conclude();
    end
endmodule // bert_core_test
